// File: rtl/pth_defines.svh
/*
 * register offsets, field positions, reset values and mode codes for the
 * period timer with hardware limit.
 * assumes inclusion by bare name from the timer and bench files.
 */
`ifndef PTH_DEFINES_SVH
`define PTH_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PTH_OFS_COUNT    6'h00
`define PTH_OFS_PERIOD   6'h04
`define PTH_OFS_CTRL     6'h08
`define PTH_OFS_LIMIT    6'h0C
`define PTH_OFS_RSTSEL   6'h10
`define PTH_OFS_STATUS   6'h14
`define PTH_OFS_MASK     6'h18

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PTH_RST_COUNT    8'h00
`define PTH_RST_PERIOD   8'hFF

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define PTH_CTRL_RUN     7
`define PTH_CTRL_PRE_HI  6
`define PTH_CTRL_PRE_LO  4
`define PTH_CTRL_OPS_HI  3
`define PTH_CTRL_OPS_LO  0

// ---------------------------------------------------------------
// mode field codes (bits 4:3 class, bits 2:0 trigger)
// ---------------------------------------------------------------
`define PTH_CLS_FREE     2'h0
`define PTH_CLS_ONESHOT  2'h1
`define PTH_CLS_MONO     2'h2
`define PTH_TRG_NONE     3'h0
`define PTH_TRG_GATE_HI  3'h1
`define PTH_TRG_GATE_LO  3'h2
`define PTH_TRG_RST_RISE 3'h3
`define PTH_TRG_RST_FALL 3'h4
`define PTH_TRG_RST_ANY  3'h5
`define PTH_TRG_RST_HI   3'h6
`define PTH_TRG_RST_LO   3'h7

// ---------------------------------------------------------------
// status bits
// ---------------------------------------------------------------
`define PTH_ST_MATCH     0
`define PTH_ST_PULSE     1
`define PTH_ST_EXTRST    2

`endif

// File: rtl/pth_pkg.sv
/*
 * types shared by the period timer.
 * assumes pth_defines.svh is available on the include path.
 */
package pth_pkg;
  // ---------------------------------------------------------------
  // bus slave request
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pth_req_t;

  // ---------------------------------------------------------------
  // signals offered to the pwm logic
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] count;
    logic       match;
    logic       tick;
  } pth_pwm_t;
endpackage : pth_pkg

// File: rtl/pth_timer.sv
/*
 * eight-bit period timer with prescaler, postscaler, external reset
 * source and avalon-mm register slave.
 * assumes ext_src pins are asynchronous; one 250 mhz clock domain.
 */
`timescale 1ns/1ps
`include "pth_defines.svh"
module pth_timer
  import pth_pkg::*;
#(
  parameter int SRC_N = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic [SRC_N-1:0] ext_src,
  input  wire logic             debug_freeze,
  output logic                  postscaled_pulse,
  output logic                  conv_trigger,
  output logic                  shutdown_src,
  output pth_pwm_t              pwm_info,
  output logic                  irq
);
  initial begin
    if (SRC_N < 2 || SRC_N > 16) $error("SRC_N must be 2..16");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pth_req_t   req;
  logic [7:0] count_r, count_nxt, period_r, period_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [4:0] limit_r, limit_nxt;
  logic [3:0] rsel_r, rsel_nxt;
  logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [6:0] pre_r, pre_nxt;
  logic [3:0] post_r, post_nxt;
  logic       pulse_r, pulse_nxt, match_r, match_nxt;
  logic       halt_r, halt_nxt;
  logic       ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [SRC_N-1:0] sync1_r, sync2_r;
  logic       src_d_r;
  logic       tick, src, rise, fall, ext_rst, gate_ok;
  logic       wr_count, wr_period, wr_ctrl, run_rise;
  logic [1:0] cls;
  logic [2:0] trg;

  assign req = '{avs_address, avs_read, avs_write, avs_writedata,
                 avs_byteenable};

  // prescale ratio 1,2,4..128 from three bits
  function automatic logic [6:0] pre_limit(input logic [2:0] sel);
    pre_limit = 7'(({6'h00, 1'b1} << sel) - 7'h01);
  endfunction : pre_limit

  // two-flop synchroniser for the external sources
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      src_d_r <= 1'b0;
    end else begin
      sync1_r <= ext_src;
      sync2_r <= sync1_r;
      src_d_r <= src;
    end
  end

  // source select and trigger decode
  assign src  = sync2_r[rsel_r[$clog2(SRC_N)-1:0]];
  assign rise = src & ~src_d_r & ~debug_freeze;
  assign fall = ~src & src_d_r & ~debug_freeze;
  assign cls  = limit_r[4:3];
  assign trg  = limit_r[2:0];

  // external reset event per trigger code
  always_comb begin
    case (trg)
      `PTH_TRG_RST_RISE: ext_rst = rise;
      `PTH_TRG_RST_FALL: ext_rst = fall;
      `PTH_TRG_RST_ANY:  ext_rst = rise | fall;
      `PTH_TRG_RST_HI:   ext_rst = src & ~debug_freeze;
      `PTH_TRG_RST_LO:   ext_rst = ~src & ~debug_freeze;
      default:           ext_rst = 1'b0;
    endcase
  end

  // gate qualification; frozen gate follows the source delayed one cycle
  always_comb begin
    case (trg)
      `PTH_TRG_GATE_HI: gate_ok = debug_freeze ? src_d_r : src;
      `PTH_TRG_GATE_LO: gate_ok = debug_freeze ? ~src_d_r : ~src;
      default:          gate_ok = 1'b1;
    endcase
  end

  // bus strobes; writes land at the edge where waitrequest is low
  assign wr_count  = req.write & req.byteenable[0]
                     & (req.address == `PTH_OFS_COUNT) & ack_r;
  assign wr_period = req.write & req.byteenable[0]
                     & (req.address == `PTH_OFS_PERIOD) & ack_r;
  assign wr_ctrl   = req.write & req.byteenable[0]
                     & (req.address == `PTH_OFS_CTRL) & ack_r;
  assign run_rise  = wr_ctrl & req.writedata[`PTH_CTRL_RUN]
                     & ~ctrl_r[`PTH_CTRL_RUN];
  assign tick = ctrl_r[`PTH_CTRL_RUN] & ~halt_r & gate_ok
                & (pre_r == pre_limit(ctrl_r[6:4]));

  // ---------------------------------------------------------------
  // timer core and register file
  // ---------------------------------------------------------------
  always_comb begin
    count_nxt  = count_r;
    period_nxt = period_r;
    ctrl_nxt   = ctrl_r;
    limit_nxt  = limit_r;
    rsel_nxt   = rsel_r;
    mask_nxt   = mask_r;
    pre_nxt    = pre_r;
    post_nxt   = post_r;
    pulse_nxt  = 1'b0;
    halt_nxt   = halt_r;
    match_nxt  = 1'b0;
    stat_nxt   = stat_r;
    ack_nxt    = 1'b0;
    rdata_nxt  = rdata_r;
    // prescaler runs while enabled, not halted and gated on
    if (ctrl_r[`PTH_CTRL_RUN] && !halt_r && gate_ok)
      pre_nxt = tick ? 7'h00 : 7'(pre_r + 7'h01);
    if (tick) begin
      if (count_r == period_r) begin
        count_nxt = `PTH_RST_COUNT;
        match_nxt = 1'b1;
        if (post_r == ctrl_r[3:0]) begin
          post_nxt  = 4'h0;
          pulse_nxt = 1'b1;
        end else begin
          post_nxt = 4'(post_r + 4'h1);
        end
        if (cls == `PTH_CLS_ONESHOT)
          ctrl_nxt[`PTH_CTRL_RUN] = 1'b0;
      end else begin
        count_nxt = 8'(count_r + 8'h01);
      end
    end
    // monostable: halt after match, run bit stays set
    if (tick && count_r == period_r && cls == `PTH_CLS_MONO)
      halt_nxt = 1'b1;
    if (ext_rst) begin
      count_nxt = `PTH_RST_COUNT;
      pre_nxt   = 7'h00;
      post_nxt  = 4'h0;
      halt_nxt  = 1'b0;
    end
    // register writes
    if (wr_count) begin
      count_nxt = req.writedata[7:0];
      pre_nxt   = 7'h00;
      post_nxt  = 4'h0;
    end
    if (wr_period) period_nxt = req.writedata[7:0];
    if (wr_ctrl) begin
      ctrl_nxt = req.writedata[7:0];
      pre_nxt  = 7'h00;
      post_nxt = 4'h0;
      halt_nxt = 1'b0;
    end
    if (req.write && req.byteenable[0] && ack_r) begin
      if (req.address == `PTH_OFS_LIMIT) limit_nxt = req.writedata[4:0];
      if (req.address == `PTH_OFS_RSTSEL) rsel_nxt = req.writedata[3:0];
      if (req.address == `PTH_OFS_MASK) mask_nxt = req.writedata[2:0];
      if (req.address == `PTH_OFS_STATUS)
        stat_nxt = stat_r & ~req.writedata[2:0];
    end
    // sticky events, set wins over clear
    stat_nxt[`PTH_ST_MATCH]  = stat_nxt[`PTH_ST_MATCH] | match_nxt;
    stat_nxt[`PTH_ST_PULSE]  = stat_nxt[`PTH_ST_PULSE] | pulse_nxt;
    stat_nxt[`PTH_ST_EXTRST] = stat_nxt[`PTH_ST_EXTRST] | ext_rst;
    // bus answer one cycle after request
    if ((req.read || req.write) && !ack_r) begin
      ack_nxt = 1'b1;
      case (req.address)
        `PTH_OFS_COUNT:  rdata_nxt = {24'h000000, count_r};
        `PTH_OFS_PERIOD: rdata_nxt = {24'h000000, period_r};
        `PTH_OFS_CTRL:   rdata_nxt = {24'h000000, ctrl_r};
        `PTH_OFS_LIMIT:  rdata_nxt = {27'h000000, limit_r};
        `PTH_OFS_RSTSEL: rdata_nxt = {28'h0000000, rsel_r};
        `PTH_OFS_STATUS: rdata_nxt = {29'h0000000, stat_r};
        `PTH_OFS_MASK:   rdata_nxt = {29'h0000000, mask_r};
        default:         rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_r  <= `PTH_RST_COUNT;
      period_r <= `PTH_RST_PERIOD;
      ctrl_r   <= 8'h00;
      limit_r  <= 5'h00;
      rsel_r   <= 4'h0;
      mask_r   <= 3'h0;
      stat_r   <= 3'h0;
      pre_r    <= 7'h00;
      post_r   <= 4'h0;
      pulse_r  <= 1'b0;
      match_r  <= 1'b0;
      halt_r   <= 1'b0;
      ack_r    <= 1'b0;
      rdata_r  <= 32'h00000000;
    end else begin
      count_r  <= count_nxt;
      period_r <= period_nxt;
      ctrl_r   <= ctrl_nxt;
      limit_r  <= limit_nxt;
      rsel_r   <= rsel_nxt;
      mask_r   <= mask_nxt;
      stat_r   <= stat_nxt;
      pre_r    <= pre_nxt;
      post_r   <= post_nxt;
      pulse_r  <= pulse_nxt;
      match_r  <= match_nxt;
      halt_r   <= halt_nxt;
      ack_r    <= ack_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign postscaled_pulse = pulse_r;
  assign conv_trigger     = pulse_r;
  assign shutdown_src     = pulse_r;
  assign pwm_info         = '{count_r, match_r, tick};
  assign avs_readdata     = rdata_r;
  assign avs_waitrequest  = (avs_read | avs_write) & ~ack_r;
  assign irq              = |(stat_r & mask_r);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  match_clears_a: assert property (
    tick && count_r == period_r && !ext_rst && !wr_count
    |=> count_r == 8'h00)
    else $error("count not cleared after match");
  count_incr_a: assert property (
    tick && count_r != period_r && !ext_rst && !wr_count
    |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not advance on tick");
  gate_hold_a: assert property (
    !gate_ok && !ext_rst && !wr_count |=> $stable(count_r))
    else $error("count moved with gate off");
  ext_reset_a: assert property (
    ext_rst && !wr_count |=> count_r == 8'h00 && post_r == 4'h0)
    else $error("external reset missed");
  ctrl_write_a: assert property (
    wr_ctrl && !wr_count && !tick && !ext_rst
    |=> $stable(count_r) && pre_r == 7'h00)
    else $error("control write disturbed count");
  pulse_width_a: assert property (
    pulse_r && !tick |=> !pulse_r)
    else $error("pulse wider than one cycle");
  oneshot_stop_a: assert property (
    tick && count_r == period_r && cls == `PTH_CLS_ONESHOT
    && !wr_ctrl && !ext_rst |=> !ctrl_r[`PTH_CTRL_RUN])
    else $error("one-shot kept running");
  mono_halt_a: assert property (
    tick && count_r == period_r && cls == `PTH_CLS_MONO
    && !wr_ctrl && !ext_rst |=> halt_r && ctrl_r[`PTH_CTRL_RUN])
    else $error("monostable did not halt");
  freeze_ignore_a: assert property (
    debug_freeze && trg >= `PTH_TRG_RST_RISE |-> !ext_rst)
    else $error("trigger taken in freeze");
  bus_answer_a: assert property (
    (avs_read || avs_write) && !ack_r |=> !avs_waitrequest)
    else $error("bus answer late");

  pulse_seen_c:   cover property (pulse_r);
  oneshot_c:      cover property (cls == `PTH_CLS_ONESHOT && match_r);
  mono_restart_c: cover property (cls == `PTH_CLS_MONO && ext_rst);
  restart_c:      cover property (run_rise);
endmodule : pth_timer

// File: dv/pth_src_model.sv
/*
 * external reset/gate source model for the period timer.
 * assumes one clock at the timer's rate; prescale 1 so one tick = one cycle.
 */
`timescale 1ns/1ps
module pth_src_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        fire,
  input  wire logic        gate_lvl,
  output logic      [15:0] ext_src
);
  logic [3:0]  hold_r;
  logic [14:0] noise_r;
  // ---------------------------------------------------------------
  // trigger level is held eight ticks per request
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_r  <= 4'h0;
      noise_r <= 15'h0000;
    end else begin
      noise_r <= noise_r + 15'h0001; // unselected sources keep moving
      if (fire) hold_r <= 4'h8;
      else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
    end
  end
  // bench spaces requests far over eight ticks apart
  assign ext_src = {noise_r, gate_lvl | (hold_r != 4'h0)};
endmodule : pth_src_model

// File: dv/testbench.sv
/*
 * self-checking bench for the period timer over its avalon-mm slave.
 * assumes the source model drives ext_src; prescale field 0 except t_period(8'h91, 16), which uses field 1.
 */
`timescale 1ns/1ps
`include "pth_defines.svh"
module testbench;
  import pth_pkg::*;
  logic        core_clk, reset, fire, gate_lvl, debug_freeze;
  logic [5:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd, rd2;
  logic [15:0] ext_src;
  logic [3:0]  avs_byteenable;
  logic        postscaled_pulse, conv_trigger, shutdown_src, irq;
  pth_pwm_t    pwm_info;
  int          n_errors, samples_checked, cyc, t_last, t_prev, pulse_n;

  pth_timer #(.SRC_N(16)) i_pth_timer (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_src(ext_src), .debug_freeze(debug_freeze),
    .postscaled_pulse(postscaled_pulse), .conv_trigger(conv_trigger),
    .shutdown_src(shutdown_src), .pwm_info(pwm_info), .irq(irq));
  pth_src_model i_pth_src_model (.core_clk(core_clk), .reset(reset),
    .fire(fire), .gate_lvl(gate_lvl), .ext_src(ext_src));

  // ---------------------------------------------------------------
  // clock, cycle count and pulse monitor
  // ---------------------------------------------------------------
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (postscaled_pulse === 1'b1) begin
      pulse_n <= pulse_n + 1;
      t_prev  <= t_last;
      t_last  <= cyc;
      check({31'h0, conv_trigger & shutdown_src}, 32'h1);
      check({23'h0, pwm_info.count, pwm_info.match}, 32'h1);
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask : rdc
  task automatic trig();
    @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask : trig

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rdc(`PTH_OFS_COUNT, 32'h00);
    rdc(`PTH_OFS_PERIOD, 32'hFF);
    rdc(`PTH_OFS_CTRL, 32'h00);
    rdc(6'h1C, 32'h00);
    wr(`PTH_OFS_PERIOD, 8'h5A);
    rdc(`PTH_OFS_PERIOD, 32'h5A);
    avs_byteenable <= 4'h0;
    wr(`PTH_OFS_PERIOD, 8'h11);
    avs_byteenable <= 4'h1;
    rdc(`PTH_OFS_PERIOD, 32'h5A);
    wr(`PTH_OFS_COUNT, 8'h03);
    wr(`PTH_OFS_CTRL, 8'h05);
    rdc(`PTH_OFS_COUNT, 32'h03);
    $display("test regs done");
  endtask : t_regs
  task automatic t_period(input logic [7:0] ctl, input int exp);
    wr(`PTH_OFS_PERIOD, 8'h03);
    wr(`PTH_OFS_MASK, 8'h02);
    wr(`PTH_OFS_CTRL, ctl);
    tick(60);
    check(t_last - t_prev, exp);
    check({31'h0, irq}, 32'h1);
    wr(`PTH_OFS_CTRL, 8'h00);
    tick(4);
    rdc(`PTH_OFS_STATUS, 32'h03);
    wr(`PTH_OFS_STATUS, 8'h07);
    rdc(`PTH_OFS_STATUS, 32'h00);
    check({31'h0, irq}, 32'h0);
    $display("test period done");
  endtask : t_period
  task automatic t_gate();
    wr(`PTH_OFS_PERIOD, 8'hFF);
    wr(`PTH_OFS_LIMIT, {3'h0, `PTH_CLS_FREE, `PTH_TRG_GATE_HI});
    wr(`PTH_OFS_CTRL, 8'h80);
    bus(1'b0, `PTH_OFS_COUNT, 8'h00, rd);
    tick(10);
    rdc(`PTH_OFS_COUNT, rd);
    gate_lvl <= 1'b1;
    tick(10);
    bus(1'b0, `PTH_OFS_COUNT, 8'h00, rd2);
    check({31'h0, rd2 != rd}, 32'h1);
    gate_lvl <= 1'b0;
    $display("test gate done");
  endtask : t_gate
  task automatic t_reset_src();
    wr(`PTH_OFS_LIMIT, {3'h0, `PTH_CLS_FREE, `PTH_TRG_RST_RISE});
    tick(100);
    trig();
    tick(8);
    bus(1'b0, `PTH_OFS_COUNT, 8'h00, rd);
    check({31'h0, rd < 32'h20}, 32'h1);
    rdc(`PTH_OFS_STATUS, 32'h04);
    debug_freeze <= 1'b1;
    tick(100);
    trig();
    tick(8);
    bus(1'b0, `PTH_OFS_COUNT, 8'h00, rd);
    check({31'h0, rd > 32'h60}, 32'h1);
    debug_freeze <= 1'b0;
    wr(`PTH_OFS_CTRL, 8'h00);
    $display("test reset source done");
  endtask : t_reset_src
  task automatic t_stop(input logic [1:0] cls);
    int p0;
    wr(`PTH_OFS_PERIOD, 8'h05);
    wr(`PTH_OFS_LIMIT, {3'h0, cls, `PTH_TRG_RST_RISE});
    wr(`PTH_OFS_CTRL, 8'h00);
    wr(`PTH_OFS_COUNT, 8'h00);
    p0 = pulse_n;
    wr(`PTH_OFS_CTRL, 8'h80);
    tick(40);
    check(pulse_n - p0, 1);
    rdc(`PTH_OFS_CTRL, (cls == `PTH_CLS_MONO) ? 32'h80 : 32'h00);
    bus(1'b0, `PTH_OFS_COUNT, 8'h00, rd);
    tick(10);
    rdc(`PTH_OFS_COUNT, rd);
    p0 = pulse_n;
    trig();
    tick(40);
    check(pulse_n - p0, (cls == `PTH_CLS_MONO) ? 1 : 0);
    $display("test stop done");
  endtask : t_stop

  // ---------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    core_clk = 1'b0; reset = 1'b1; fire = 1'b0; gate_lvl = 1'b0;
    debug_freeze = 1'b0; avs_address = 6'h00; avs_read = 1'b0;
    avs_write = 1'b0; avs_writedata = 32'h0; n_errors = 0;
    avs_byteenable = 4'h1;
    samples_checked = 0; cyc = 0; t_last = 0; t_prev = 0; pulse_n = 0;
    tick(10);
    reset <= 1'b0;
    t_regs();
    t_period(8'h80, 4);
    t_period(8'h91, 16);
    t_gate();
    t_reset_src();
    t_stop(`PTH_CLS_ONESHOT);
    t_stop(`PTH_CLS_MONO);
    summarize();
  end
endmodule : testbench
